/* File: hdl/asd_pkg.sv */
// Purpose: Shared constants and types for the add/logic/shift operand datapath
// Assumes: 16-bit working registers, 40-bit accumulators, one instruction per clock
// Notes: Prefetch selector codes 0-6 use the even pointer, 7-13 the odd one, 14 indexed, 15 none
package asd_pkg;

  // ==========================================================
  // Widths and bit positions
  localparam int DW = 16;
  localparam int ACW = 40;
  localparam int FAW = 13;
  localparam int NREG = 16;
  localparam int SIGN = 15;
  localparam int NIB = 4;
  localparam int LIT5_MSB = 4;
  localparam int ACC_LSW = 16;
  localparam int ACC_GUARD = 31;

  // ==========================================================
  // Register indices and selector codes
  localparam logic [3:0] DEFAULT_FILE_WORKING_REG = 4'h0;
  localparam logic [3:0] MAC_BASE = 4'h4;
  localparam logic [3:0] X_PTR = 4'h8;
  localparam logic [3:0] Y_PTR = 4'ha;
  localparam logic [3:0] IDX_REG = 4'hc;
  localparam logic [3:0] PF_GROUP = 4'h7;
  localparam logic [3:0] PF_INDEXED = 4'he;
  localparam logic [3:0] PF_NONE = 4'hf;
  localparam logic [2:0] PAIR_COUNT = 3'h6;
  localparam logic [0:5][3:0] PAIR_A = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6};
  localparam logic [0:5][3:0] PAIR_B = '{4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h7};
  localparam logic [0:6][3:0] PF_STEP = '{4'h6, 4'h4, 4'h2, 4'h0, 4'ha, 4'hc, 4'he};

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ASD_NOP, ASD_ADD, ASD_SUM_WITH_CARRY_OP, ASD_AND, ASD_ARITH_SHIFT_RIGHT_OP,
    ASD_ADD_ACC, ASD_SQR, ASD_MPY, ASD_DIV
  } asd_op_t;

  typedef enum logic [2:0] {ASD_F, ASD_F_TO_W0, ASD_LIT10, ASD_REG3, ASD_LIT5} asd_form_t;

  typedef struct packed {
    logic valid;
    asd_op_t op;
    asd_form_t form;
    logic [FAW-1:0] fAddr;
    logic [DW-1:0] fData;
    logic [3:0] baseWorkingReg;
    logic [3:0] srcReg;
    logic [3:0] dstReg;
    logic [9:0] lit;
    logic [3:0] signedShiftLiteral;
    logic accSel;
    logic [2:0] mulSel;
    logic [3:0] xPrefetchAddrSel;
    logic [3:0] yPrefetchAddrSel;
    logic [1:0] xDst;
    logic [1:0] yDst;
  } asd_cmd_t;

  typedef struct packed {
    logic carry;
    logic digitCarryFlag;
    logic negative;
    logic arithExcessFlag;
    logic zero;
  } asd_flags_t;

  typedef struct packed {
    logic accAExcessFlag;
    logic accBExcessFlag;
    logic accAClippedFlag;
    logic accBClippedFlag;
  } asd_accflags_t;

  typedef struct packed {
    logic en;
    logic idx;
    logic [3:0] ptr;
    logic [3:0] step;
  } asd_pf_t;

endpackage

/* File: hdl/asd_datapath.sv */
// Purpose: One-cycle add, add-with-carry, AND, shift and MAC operand datapath
// Assumes: Decoder presents one command per clock; data memory reads are combinational
// Notes: Working registers, flags and accumulators live here
//
// Functional notes
// - File-register forms that name the default register use W0 as operand and target.
// - Base, source and destination fields pick any of sixteen working registers.
// - Square takes both factors from one register among W4 to W7.
// - Multiply takes its factors from one of six distinct pairs among W4 to W7.
// - X prefetch uses W8 or W9 plain or stepped by plus or minus 2, 4 or 6, W9 plus W12, or none.
// - Y prefetch uses W10 or W11 plain or stepped by plus or minus 2, 4 or 6, W11 plus W12, or none.
// - Prefetched data lands only in W4 to W7.
// - Divide reads dividend and divisor directly from a register pair.
// - Signed add to accumulator adds a shifted 16-bit source and updates its flags.
// - Add-with-carry adds both operands and carry and updates all five flags.
// - Add-with-carry also adds a base register, a 5-bit literal and carry.
// - Arithmetic right shift keeps the sign and updates carry, negative, overflow, zero.
// - Status holds carry, digit carry, negative, overflow and zero.
// - Each accumulator has its own overflow and saturation flags.
`timescale 1ns/1ps

module asd_datapath (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire asd_pkg::asd_cmd_t cmd,
  input wire logic clipClear,
  input wire logic [15:0] xRdData,
  input wire logic [15:0] yRdData,
  output logic resValid,
  output logic [15:0] resData,
  output logic fileWrEn,
  output logic [12:0] fileWrAddr,
  output logic [15:0] fileWrData,
  output asd_pkg::asd_flags_t flags,
  output asd_pkg::asd_accflags_t accFlags,
  output logic signed [39:0] accA,
  output logic signed [39:0] accB,
  output logic xRdEn,
  output logic [15:0] xAddr,
  output logic yRdEn,
  output logic [15:0] yAddr,
  output logic divValid,
  output logic [15:0] dividend,
  output logic [15:0] divisor
);

  localparam int DW = asd_pkg::DW;
  localparam int ACW = asd_pkg::ACW;
  localparam int NIB = asd_pkg::NIB;
  localparam int SIGN = asd_pkg::SIGN;

  // ==========================================================
  // Reset release
  logic rstMeta;
  logic rstSync;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ==========================================================
  // Prefetch selector decode
  function automatic asd_pkg::asd_pf_t pfDecode(input logic [3:0] sel, input logic [3:0] base);
    asd_pkg::asd_pf_t pf;
    logic [3:0] k;
    pf = '0;
    k = (sel >= asd_pkg::PF_GROUP) ? sel - asd_pkg::PF_GROUP : sel;
    pf.en = (sel != asd_pkg::PF_NONE);
    pf.idx = (sel == asd_pkg::PF_INDEXED);
    pf.ptr = (sel >= asd_pkg::PF_GROUP) ? base + 4'h1 : base;
    pf.step = (k < asd_pkg::PF_GROUP) ? asd_pkg::PF_STEP[k[2:0]] : 4'h0;
    return pf;
  endfunction

  // ==========================================================
  // State
  logic [15:0] default_file_working_reg [asd_pkg::NREG];
  logic [15:0] next_default_file_working_reg [asd_pkg::NREG];
  asd_pkg::asd_flags_t next_flags;
  asd_pkg::asd_accflags_t next_accFlags;
  logic signed [39:0] next_accA;
  logic signed [39:0] next_accB;
  logic next_resValid;
  logic [15:0] next_resData;
  logic next_fileWrEn;
  logic [12:0] next_fileWrAddr;
  logic [15:0] next_fileWrData;
  logic next_xRdEn;
  logic [15:0] next_xAddr;
  logic next_yRdEn;
  logic [15:0] next_yAddr;
  logic [1:0] xDst;
  logic [1:0] next_xDst;
  logic [1:0] yDst;
  logic [1:0] next_yDst;
  logic next_divValid;
  logic [15:0] next_dividend;
  logic [15:0] next_divisor;

  // ==========================================================
  // Operand selection
  logic isAlu;
  logic isMac;
  logic [15:0] opA;
  logic [15:0] opB;
  logic toFile;
  logic [3:0] dstIdx;
  logic carryIn;
  logic [16:0] sum;
  logic [4:0] nibSum;
  logic [15:0] aluRes;
  logic [15:0] divA;
  logic [15:0] divB;

  assign isAlu = cmd.valid && (cmd.op inside {asd_pkg::ASD_ADD, asd_pkg::ASD_SUM_WITH_CARRY_OP,
                 asd_pkg::ASD_AND, asd_pkg::ASD_ARITH_SHIFT_RIGHT_OP});
  assign isMac = cmd.valid && (cmd.op inside {asd_pkg::ASD_SQR, asd_pkg::ASD_MPY});
  assign divA = default_file_working_reg[cmd.baseWorkingReg];
  assign divB = default_file_working_reg[cmd.srcReg];

  always_comb
  begin
    opA = '0;
    opB = '0;
    toFile = 1'b0;
    dstIdx = cmd.dstReg;
    case (cmd.form)
      asd_pkg::ASD_F:
      begin
        opA = cmd.fData;
        opB = default_file_working_reg[asd_pkg::DEFAULT_FILE_WORKING_REG];
        toFile = 1'b1;
      end
      asd_pkg::ASD_F_TO_W0:
      begin
        opA = cmd.fData;
        opB = default_file_working_reg[asd_pkg::DEFAULT_FILE_WORKING_REG];
        dstIdx = asd_pkg::DEFAULT_FILE_WORKING_REG;
      end
      asd_pkg::ASD_LIT10:
      begin
        opA = DW'(cmd.lit);
        opB = default_file_working_reg[cmd.dstReg];
      end
      asd_pkg::ASD_REG3:
      begin
        opA = default_file_working_reg[cmd.baseWorkingReg];
        opB = default_file_working_reg[cmd.srcReg];
      end
      asd_pkg::ASD_LIT5:
      begin
        opA = default_file_working_reg[cmd.baseWorkingReg];
        opB = DW'(cmd.lit[asd_pkg::LIT5_MSB:0]);
      end
      default:
      begin
        opA = '0;
      end
    endcase
  end

  assign carryIn = (cmd.op == asd_pkg::ASD_SUM_WITH_CARRY_OP) && flags.carry;
  assign sum = (DW + 1)'(opA) + (DW + 1)'(opB) + (DW + 1)'(carryIn);
  assign nibSum = (NIB + 1)'(opA[NIB-1:0]) + (NIB + 1)'(opB[NIB-1:0]) + (NIB + 1)'(carryIn);

  // ==========================================================
  // Multiplier and accumulator operands
  logic [3:0] mA;
  logic [3:0] mB;
  logic signed [31:0] prod;
  logic signed [39:0] curAcc;
  logic signed [39:0] aligned;
  logic signed [39:0] addend;
  logic signed [39:0] accSum;
  logic accSat;
  logic accExcess;

  always_comb
  begin
    if (cmd.op == asd_pkg::ASD_SQR)
    begin
      mA = asd_pkg::MAC_BASE + {2'b00, cmd.mulSel[1:0]};
      mB = mA;
    end
    else if (cmd.mulSel < asd_pkg::PAIR_COUNT)
    begin
      mA = asd_pkg::PAIR_A[cmd.mulSel];
      mB = asd_pkg::PAIR_B[cmd.mulSel];
    end
    else
    begin
      mA = asd_pkg::PAIR_A[0];
      mB = asd_pkg::PAIR_B[0];
    end
  end

  assign prod = $signed(default_file_working_reg[mA]) * $signed(default_file_working_reg[mB]);
  assign curAcc = cmd.accSel ? accB : accA;
  assign aligned = ACW'($signed(default_file_working_reg[cmd.srcReg])) <<< asd_pkg::ACC_LSW;
  // Positive shift literal moves right, negative moves left
  assign addend = cmd.signedShiftLiteral[3] ? aligned <<< 4'(-cmd.signedShiftLiteral)
                                            : aligned >>> cmd.signedShiftLiteral;
  assign accSum = (cmd.op == asd_pkg::ASD_ADD_ACC) ? curAcc + addend : ACW'(prod);
  assign accSat = cmd.valid && (cmd.op == asd_pkg::ASD_ADD_ACC) && (curAcc[ACW-1] == addend[ACW-1])
                  && (accSum[ACW-1] != curAcc[ACW-1]);
  assign accExcess = !((&accSum[ACW-1:asd_pkg::ACC_GUARD]) || !(|accSum[ACW-1:asd_pkg::ACC_GUARD]));

  // ==========================================================
  // Prefetch address generation
  asd_pkg::asd_pf_t pfX;
  asd_pkg::asd_pf_t pfY;
  logic [15:0] xAddrNew;
  logic [15:0] yAddrNew;

  assign pfX = pfDecode(cmd.xPrefetchAddrSel, asd_pkg::X_PTR);
  assign pfY = pfDecode(cmd.yPrefetchAddrSel, asd_pkg::Y_PTR);
  assign xAddrNew = pfX.idx ? default_file_working_reg[pfX.ptr] + default_file_working_reg[asd_pkg::IDX_REG] : default_file_working_reg[pfX.ptr];
  assign yAddrNew = pfY.idx ? default_file_working_reg[pfY.ptr] + default_file_working_reg[asd_pkg::IDX_REG] : default_file_working_reg[pfY.ptr];

  // ==========================================================
  // Next state
  always_comb
  begin
    next_default_file_working_reg = default_file_working_reg;
    next_flags = flags;
    next_accFlags = accFlags;
    next_accA = accA;
    next_accB = accB;
    next_resValid = 1'b0;
    next_resData = resData;
    next_fileWrEn = 1'b0;
    next_fileWrAddr = fileWrAddr;
    next_fileWrData = fileWrData;
    next_xRdEn = 1'b0;
    next_xAddr = xAddr;
    next_xDst = xDst;
    next_yRdEn = 1'b0;
    next_yAddr = yAddr;
    next_yDst = yDst;
    next_divValid = 1'b0;
    next_dividend = dividend;
    next_divisor = divisor;
    aluRes = sum[DW-1:0];
    case (cmd.op)
      asd_pkg::ASD_ADD, asd_pkg::ASD_SUM_WITH_CARRY_OP:
      begin
        next_flags.carry = sum[DW];
        next_flags.digitCarryFlag = nibSum[NIB];
        next_flags.arithExcessFlag = (opA[SIGN] == opB[SIGN]) && (sum[SIGN] != opA[SIGN]);
      end
      asd_pkg::ASD_AND:
      begin
        aluRes = opA & opB;
      end
      asd_pkg::ASD_ARITH_SHIFT_RIGHT_OP:
      begin
        aluRes = {opA[SIGN], opA[SIGN:1]};
        next_flags.carry = opA[0];
        next_flags.arithExcessFlag = 1'b0;
      end
      default:
      begin
        aluRes = sum[DW-1:0];
      end
    endcase
    if (isAlu)
    begin
      // All covered forms retire in this one edge
      next_flags.negative = aluRes[SIGN];
      next_flags.zero = (aluRes == '0);
      next_resValid = 1'b1;
      next_resData = aluRes;
      if (toFile)
      begin
        next_fileWrEn = 1'b1;
        next_fileWrAddr = cmd.fAddr;
        next_fileWrData = aluRes;
      end
      else
      begin
        next_default_file_working_reg[dstIdx] = aluRes;
      end
    end
    if (!cmd.valid)
    begin
      next_flags = flags;
    end
    if ((isMac || (cmd.valid && cmd.op == asd_pkg::ASD_ADD_ACC)))
    begin
      if (cmd.accSel)
      begin
        next_accB = accSum;
        next_accFlags.accBExcessFlag = accExcess;
      end
      else
      begin
        next_accA = accSum;
        next_accFlags.accAExcessFlag = accExcess;
      end
    end
    if (isMac && pfX.en)
    begin
      next_xRdEn = 1'b1;
      next_xAddr = xAddrNew;
      next_xDst = cmd.xDst;
      if (!pfX.idx)
      begin
        next_default_file_working_reg[pfX.ptr] = default_file_working_reg[pfX.ptr] + {{12{pfX.step[3]}}, pfX.step};
      end
    end
    if (isMac && pfY.en)
    begin
      next_yRdEn = 1'b1;
      next_yAddr = yAddrNew;
      next_yDst = cmd.yDst;
      if (!pfY.idx)
      begin
        next_default_file_working_reg[pfY.ptr] = default_file_working_reg[pfY.ptr] + {{12{pfY.step[3]}}, pfY.step};
      end
    end
    // Data returned for last cycle's prefetch overrides any ALU write, and Y data overrides X data
    if (xRdEn)
    begin
      next_default_file_working_reg[asd_pkg::MAC_BASE + {2'b00, xDst}] = xRdData;
    end
    if (yRdEn)
    begin
      next_default_file_working_reg[asd_pkg::MAC_BASE + {2'b00, yDst}] = yRdData;
    end
    if (cmd.valid && cmd.op == asd_pkg::ASD_DIV)
    begin
      next_divValid = 1'b1;
      next_dividend = divA;
      next_divisor = divB;
    end
    // A new saturation event wins over a clear in the same cycle
    if (clipClear)
    begin
      next_accFlags.accAClippedFlag = 1'b0;
      next_accFlags.accBClippedFlag = 1'b0;
    end
    if (accSat && !cmd.accSel)
    begin
      next_accFlags.accAClippedFlag = 1'b1;
    end
    if (accSat && cmd.accSel)
    begin
      next_accFlags.accBClippedFlag = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      for (int i = 0; i < asd_pkg::NREG; i++)
      begin
        default_file_working_reg[i] <= '0;
      end
      flags <= '0;
      accFlags <= '0;
      accA <= '0;
      accB <= '0;
      resValid <= 1'b0;
      resData <= '0;
      fileWrEn <= 1'b0;
      fileWrAddr <= '0;
      fileWrData <= '0;
      xRdEn <= 1'b0;
      xAddr <= '0;
      xDst <= '0;
      yRdEn <= 1'b0;
      yAddr <= '0;
      yDst <= '0;
      divValid <= 1'b0;
      dividend <= '0;
      divisor <= '0;
    end
    else
    begin
      default_file_working_reg <= next_default_file_working_reg;
      flags <= next_flags;
      accFlags <= next_accFlags;
      accA <= next_accA;
      accB <= next_accB;
      resValid <= next_resValid;
      resData <= next_resData;
      fileWrEn <= next_fileWrEn;
      fileWrAddr <= next_fileWrAddr;
      fileWrData <= next_fileWrData;
      xRdEn <= next_xRdEn;
      xAddr <= next_xAddr;
      xDst <= next_xDst;
      yRdEn <= next_yRdEn;
      yAddr <= next_yAddr;
      yDst <= next_yDst;
      divValid <= next_divValid;
      dividend <= next_dividend;
      divisor <= next_divisor;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync);

  sequence sIssueX;
    isMac && pfX.en;
  endsequence
  sequence sLandX;
    xRdEn && xAddr == $past(xAddrNew);
  endsequence
  sequence sIssueY;
    isMac && pfY.en;
  endsequence
  sequence sLandY;
    yRdEn && yAddr == $past(yAddrNew);
  endsequence

  w0_target_a: assert property (isAlu && cmd.form == asd_pkg::ASD_F_TO_W0
    |=> default_file_working_reg[asd_pkg::DEFAULT_FILE_WORKING_REG] == resData && !fileWrEn)
    else $error("default register result not in W0");
  reg_pick_a: assert property (isAlu && cmd.form == asd_pkg::ASD_REG3 && !xRdEn && !yRdEn
    |=> default_file_working_reg[$past(cmd.dstReg)] == resData)
    else $error("result not in chosen register");
  square_pick_a: assert property (cmd.valid && cmd.op == asd_pkg::ASD_SQR
    |-> mA == mB && mA[3:2] == asd_pkg::MAC_BASE[3:2])
    else $error("square factors wrong");
  pair_pick_a: assert property (cmd.valid && cmd.op == asd_pkg::ASD_MPY
    |-> mA < mB && mA[3:2] == asd_pkg::MAC_BASE[3:2] && mB[3:2] == asd_pkg::MAC_BASE[3:2])
    else $error("multiply pair wrong");
  x_fetch_a: assert property (sIssueX |=> sLandX)
    else $error("x prefetch address wrong");
  y_fetch_a: assert property (sIssueY |=> sLandY)
    else $error("y prefetch address wrong");
  fetch_dest_a: assert property (xRdEn && !(yRdEn && yDst == xDst)
    |=> default_file_working_reg[asd_pkg::MAC_BASE + {2'b00, $past(xDst)}] == $past(xRdData))
    else $error("prefetch data misplaced");
  div_direct_a: assert property (cmd.valid && cmd.op == asd_pkg::ASD_DIV
    |=> divValid && dividend == $past(divA) && divisor == $past(divB))
    else $error("divide operands wrong");
  acc_add_a: assert property (cmd.valid && cmd.op == asd_pkg::ASD_ADD_ACC && !cmd.accSel
    |=> accA == $past(accSum) && accFlags.accAExcessFlag == $past(accExcess))
    else $error("accumulator add wrong");
  carry_sum_a: assert property (isAlu && cmd.op == asd_pkg::ASD_SUM_WITH_CARRY_OP
    |=> resData == DW'($past(opA) + $past(opB) + DW'($past(flags.carry))))
    else $error("carry sum wrong");
  lit5_sum_a: assert property (isAlu && cmd.op == asd_pkg::ASD_SUM_WITH_CARRY_OP
    && cmd.form == asd_pkg::ASD_LIT5 |=> resData[4:0] == 5'($past(opA) + $past(opB)
    + DW'($past(flags.carry))))
    else $error("literal carry sum wrong");
  shift_sign_a: assert property (isAlu && cmd.op == asd_pkg::ASD_ARITH_SHIFT_RIGHT_OP
    |=> resData[SIGN] == resData[SIGN-1] && flags.carry == $past(opA[0])
    && !flags.arithExcessFlag)
    else $error("shift result wrong");
  zero_neg_a: assert property (isAlu |=> flags.zero == (resData == '0)
    && flags.negative == resData[SIGN])
    else $error("zero or negative flag wrong");
  clip_sticky_a: assert property (accFlags.accAClippedFlag && !clipClear
    |=> accFlags.accAClippedFlag)
    else $error("saturation flag lost");
  and_flags_a: assert property (isAlu && cmd.op == asd_pkg::ASD_AND
    |=> flags.carry == $past(flags.carry) && flags.digitCarryFlag == $past(flags.digitCarryFlag)
    && flags.arithExcessFlag == $past(flags.arithExcessFlag))
    else $error("logic op touched arithmetic flags");
  one_cycle_a: assert property (isAlu |=> resValid)
    else $error("result late");

endmodule

/* File: bench/asd_data_mem.sv */
// Purpose: Data memory model answering the X and Y prefetch reads
// Assumes: Read data is combinational while the read enable is high
// Notes: An idle read bus shows a pattern that flips every cycle
`timescale 1ns/1ps

module asd_data_mem (
  input wire logic sys_clk,
  input wire logic xRdEn,
  input wire logic [15:0] xAddr,
  input wire logic yRdEn,
  input wire logic [15:0] yAddr,
  output logic [15:0] xRdData,
  output logic [15:0] yRdData
);
  logic [15:0] junk = 16'h0f0f;

  // ====================
  // Read ports
  always @(posedge sys_clk) junk <= ~junk;
  assign xRdData = xRdEn ? (xAddr ^ 16'ha5c3) : junk;
  assign yRdData = yRdEn ? (yAddr ^ 16'h3c5a) : ~junk;
endmodule

/* File: bench/test_add_logic_shift_operand_datapath.sv */
// Purpose: Self-checking bench for the operand datapath
// Assumes: One command per clock, inputs driven on the falling edge
// Notes: A model mirrors W0-W15, status flags and both accumulators
`timescale 1ns/1ps

module test_add_logic_shift_operand_datapath;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clipClear = 1'b0;
  asd_pkg::asd_cmd_t cmd = '0;
  logic [15:0] xRdData, yRdData, resData, fileWrData, xAddr, yAddr, dividend, divisor;
  logic resValid, fileWrEn, xRdEn, yRdEn, divValid;
  logic [12:0] fileWrAddr;
  asd_pkg::asd_flags_t flags;
  asd_pkg::asd_accflags_t accFlags;
  logic signed [39:0] accA, accB;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] w [16];
  asd_pkg::asd_flags_t ef;
  logic signed [39:0] ea [2];
  logic [1:0] ecl = 2'b00;
  int stepv [7] = '{6, 4, 2, 0, -6, -4, -2};
  logic [3:0] shv [6] = '{4'h0, 4'h1, 4'h7, 4'hf, 4'h9, 4'hc};

  asd_datapath dut_u (.sys_clk, .rst_b, .cmd, .clipClear, .xRdData, .yRdData, .resValid,
    .resData, .fileWrEn, .fileWrAddr, .fileWrData, .flags, .accFlags, .accA, .accB, .xRdEn,
    .xAddr, .yRdEn, .yAddr, .divValid, .dividend, .divisor);
  asd_data_mem mem_u (.sys_clk, .xRdEn, .xAddr, .yRdEn, .yAddr, .xRdData, .yRdData);

  // ====================
  // Clock, timeout and verdict
  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic excess(input logic [39:0] a);
    return !(&a[39:31] || !(|a[39:31]));
  endfunction

  // ====================
  // Command access
  task automatic issue(input asd_pkg::asd_cmd_t c);
    cmd = c;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic idle();
    cmd.valid = 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  function automatic asd_pkg::asd_cmd_t mk(input asd_pkg::asd_op_t op,
      input asd_pkg::asd_form_t fm, input logic [3:0] b, input logic [3:0] s,
      input logic [3:0] d, input logic [9:0] lit);
    asd_pkg::asd_cmd_t c;
    c = '0;
    c.valid = 1'b1;
    c.op = op;
    c.form = fm;
    c.fAddr = 13'h1a5c;
    c.baseWorkingReg = b;
    c.srcReg = s;
    c.dstReg = d;
    c.lit = lit;
    c.xPrefetchAddrSel = 4'hf;
    c.yPrefetchAddrSel = 4'hf;
    return c;
  endfunction

  task automatic alu(input asd_pkg::asd_op_t op, input asd_pkg::asd_form_t fm,
      input logic [3:0] b, input logic [3:0] s, input logic [3:0] d, input logic [9:0] lit,
      input logic [15:0] fd);
    asd_pkg::asd_cmd_t c;
    logic [15:0] a, o, r;
    logic [16:0] sum;
    logic ci, isf;
    c = mk(op, fm, b, s, d, lit);
    c.fData = fd;
    isf = (fm == asd_pkg::ASD_F);
    a = (fm <= asd_pkg::ASD_F_TO_W0) ? fd : (fm == asd_pkg::ASD_LIT10) ? {6'h0, lit} : w[b];
    o = (fm <= asd_pkg::ASD_F_TO_W0) ? w[0] : (fm == asd_pkg::ASD_LIT10) ? w[d]
      : (fm == asd_pkg::ASD_REG3) ? w[s] : {11'h0, lit[4:0]};
    ci = (op == asd_pkg::ASD_SUM_WITH_CARRY_OP) ? ef.carry : 1'b0;
    sum = a + o + ci;
    r = sum[15:0];
    if (op == asd_pkg::ASD_AND)
      r = a & o;
    if (op == asd_pkg::ASD_ARITH_SHIFT_RIGHT_OP)
      r = {a[15], a[15:1]};
    if (op == asd_pkg::ASD_ADD || op == asd_pkg::ASD_SUM_WITH_CARRY_OP)
    begin
      ef.carry = sum[16];
      ef.digitCarryFlag = ({1'b0, a[3:0]} + o[3:0] + ci) > 5'hf;
      ef.arithExcessFlag = (a[15] == o[15]) && (r[15] != a[15]);
    end
    if (op == asd_pkg::ASD_ARITH_SHIFT_RIGHT_OP)
    begin
      ef.carry = a[0];
      ef.arithExcessFlag = 1'b0;
    end
    ef.negative = r[15];
    ef.zero = (r == 16'h0);
    issue(c);
    chk("resValid", 1, resValid);
    chk("resData", r, resData);
    chk("flags", ef, flags);
    chk("fileWrEn", isf, fileWrEn);
    if (isf)
      chk("fileWr", {13'h1a5c, r}, {fileWrAddr, fileWrData});
    else
      w[(fm == asd_pkg::ASD_F_TO_W0) ? 4'h0 : d] = r;
  endtask

  task automatic rd(input logic [3:0] n);
    alu(asd_pkg::ASD_AND, asd_pkg::ASD_REG3, n, n, n, 10'h0, 16'h0);
  endtask

  // Goes through W0, so W0 is loaded last when needed
  task automatic loadw(input logic [3:0] n, input logic [15:0] v);
    alu(asd_pkg::ASD_AND, asd_pkg::ASD_F_TO_W0, 0, 0, 0, 10'h0, 16'h0);
    alu(asd_pkg::ASD_ADD, asd_pkg::ASD_F_TO_W0, 0, 0, 0, 10'h0, v);
    if (n != 4'h0)
    begin
      alu(asd_pkg::ASD_AND, asd_pkg::ASD_LIT10, 0, 0, n, 10'h0, 16'h0);
      alu(asd_pkg::ASD_ADD, asd_pkg::ASD_REG3, 0, n, n, 10'h0, 16'h0);
    end
  endtask

  task automatic pf(input logic [3:0] s, input int base, output logic en,
      output logic [15:0] ad);
    int p;
    p = base + (s > 4'h6);
    en = (s != 4'hf);
    ad = (s == 4'he) ? w[base + 1] + w[12] : w[p];
    if (s < 4'he)
      w[p] = 16'(w[p] + stepv[s % 7]);
  endtask

  task automatic mac(input asd_pkg::asd_op_t op, input logic [3:0] sel, input logic as,
      input logic [3:0] xs, input logic [3:0] ys, input logic [3:0] src, input logic [3:0] sh);
    asd_pkg::asd_cmd_t c;
    logic [7:0] pq;
    logic [15:0] xa, ya;
    logic xe, ye, mul, sat;
    logic signed [39:0] e;
    c = mk(op, asd_pkg::ASD_REG3, sel, src, 4'h0, 10'h0);
    c.mulSel = sel[2:0];
    c.accSel = as;
    c.signedShiftLiteral = sh;
    c.xPrefetchAddrSel = xs;
    c.yPrefetchAddrSel = ys;
    c.xDst = sel[1:0];
    c.yDst = sel[1:0] + 2'h1;
    mul = (op == asd_pkg::ASD_SQR || op == asd_pkg::ASD_MPY);
    pq = (sel == 4'h0) ? 8'h45 : (sel == 4'h1) ? 8'h46 : (sel == 4'h2) ? 8'h47
      : (sel == 4'h3) ? 8'h56 : (sel == 4'h4) ? 8'h57 : 8'h67;
    if (op == asd_pkg::ASD_SQR)
      pq = {2{2'b01, sel[1:0]}};
    e = $signed(w[pq[7:4]]) * $signed(w[pq[3:0]]);
    if (mul)
      ea[as] = e;
    e = {{8{w[src][15]}}, w[src], 16'h0};
    e = sh[3] ? e <<< (16 - sh) : e >>> sh;
    if (op == asd_pkg::ASD_ADD_ACC)
    begin
      sat = (ea[as][39] == e[39]);
      ea[as] = ea[as] + e;
      if (sat && ea[as][39] != e[39])
        ecl[!as] = 1'b1;
    end
    xe = 1'b0;
    ye = 1'b0;
    if (mul)
    begin
      pf(xs, 8, xe, xa);
      pf(ys, 10, ye, ya);
    end
    issue(c);
    chk("xRdEn", xe, xRdEn);
    if (xe)
      chk("xAddr", xa, xAddr);
    chk("yRdEn", ye, yRdEn);
    if (ye)
      chk("yAddr", ya, yAddr);
    chk("accA", ea[0], accA);
    chk("accB", ea[1], accB);
    chk("accFlags", {excess(ea[0]), excess(ea[1]), ecl}, accFlags);
    chk("flags", ef, flags);
    chk("divValid", op == asd_pkg::ASD_DIV, divValid);
    if (op == asd_pkg::ASD_DIV)
      chk("divide", {w[sel], w[src]}, {dividend, divisor});
    idle();
    if (xe)
      w[4 + c.xDst] = xa ^ 16'ha5c3;
    if (ye)
      w[4 + c.yDst] = ya ^ 16'h3c5a;
  endtask

  // ====================
  // Main sequence
  initial
  begin
    foreach (w[i]) w[i] = 16'h0;
    ef = '0;
    ea[0] = 40'sh0;
    ea[1] = 40'sh0;
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("resetOut", 0, {flags, accFlags, resValid});
    chk("resetAcc", 0, accA);
    for (int i = 15; i >= 0; i--)
      loadw(4'(i), 16'(16'h1357 * i + 16'h0f));
    for (int i = 0; i < 16; i++)
      rd(4'(i));
    loadw(4'h1, 16'h7fff);
    loadw(4'h2, 16'h0001);
    loadw(4'h4, 16'hffff);
    alu(asd_pkg::ASD_ADD, asd_pkg::ASD_REG3, 1, 2, 3, 10'h0, 16'h0);
    alu(asd_pkg::ASD_ADD, asd_pkg::ASD_REG3, 4, 2, 5, 10'h0, 16'h0);
    alu(asd_pkg::ASD_SUM_WITH_CARRY_OP, asd_pkg::ASD_REG3, 2, 2, 6, 10'h0, 16'h0);
    alu(asd_pkg::ASD_SUM_WITH_CARRY_OP, asd_pkg::ASD_LIT5, 4, 0, 7, 10'h3e1, 16'h0);
    alu(asd_pkg::ASD_AND, asd_pkg::ASD_LIT10, 0, 0, 4, 10'h2aa, 16'h0);
    alu(asd_pkg::ASD_SUM_WITH_CARRY_OP, asd_pkg::ASD_LIT5, 2, 0, 8, 10'h3ff, 16'h0);
    for (int k = 1; k < 5; k++)
      for (int f = 0; f < 5; f++)
        if (k < 4 || f < 2)
          alu(asd_pkg::asd_op_t'(k), asd_pkg::asd_form_t'(f), 4'(f), 4'h4, 4'h9, 10'h3c6,
            16'(16'h8001 + k));
    idle();
    chk("resValid", 0, resValid);
    loadw(4'h4, 16'h0003);
    loadw(4'h5, 16'hfffb);
    loadw(4'h6, 16'h0007);
    loadw(4'h7, 16'h0100);
    for (int k = 0; k < 6; k++)
      mac(asd_pkg::ASD_MPY, 4'(k), k[0], 4'hf, 4'hf, 4'h0, 4'h0);
    for (int k = 0; k < 4; k++)
      mac(asd_pkg::ASD_SQR, 4'(k), k[0], 4'hf, 4'hf, 4'h0, 4'h0);
    for (int k = 8; k < 13; k++)
      loadw(4'(k), 16'(k * 16'h1000 + 16'h10));
    for (int k = 0; k < 16; k++)
      mac(asd_pkg::ASD_MPY, 4'(k % 6), k[0], 4'(k), 4'(15 - k), 4'h0, 4'h0);
    for (int k = 4; k < 13; k++)
      rd(4'(k));
    loadw(4'h3, 16'h4000);
    loadw(4'h2, 16'h8000);
    clipClear = 1'b1;
    idle();
    clipClear = 1'b0;
    for (int k = 0; k < 6; k++)
      mac(asd_pkg::ASD_ADD_ACC, 4'h0, k[0], 4'hf, 4'hf, 4'(2 + k[0]), shv[k]);
    // Drive accumulator A past the 40-bit range, then clear the sticky flag
    mac(asd_pkg::ASD_ADD_ACC, 4'h0, 1'b0, 4'hf, 4'hf, 4'h2, 4'h9);
    chk("accAClipped", 1, accFlags.accAClippedFlag);
    clipClear = 1'b1;
    ecl = 2'b00;
    idle();
    clipClear = 1'b0;
    chk("clipClear", ecl, accFlags[1:0]);
    for (int k = 0; k < 3; k++)
      mac(asd_pkg::ASD_DIV, 4'(k * 5), 1'b0, 4'hf, 4'hf, 4'(15 - k), 4'h0);
    conclude();
  end
endmodule
